// *** aas_pkg.sv ***
// aas_pkg: shared constants and types of the amplifier sample sequencer.
// assumes: one system clock of 200 MHz and one spi link clock.
package aas_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ          = 200_000_000;
	localparam int SAMPLE_HZ       = 20_000;
	// exact division, so no rounding question arises
	localparam int TICK_CYCLES_DEF = CLK_HZ / SAMPLE_HZ;

	// ------------------------------------------------------------
	// burst shapes of the two amplifier variants
	// ------------------------------------------------------------
	localparam int REC_NUM_CONV = 32;
	localparam int REC_NUM_AUX  = 3;
	localparam int REC_WORD_W   = 16;
	localparam int STM_NUM_CONV = 16;
	localparam int STM_NUM_AUX  = 4;
	localparam int STM_WORD_W   = 32;

	// ------------------------------------------------------------
	// acquisition and buffering
	// ------------------------------------------------------------
	localparam int OFFLINE_SAMPLES = 10000;
	localparam int STORE_DEPTH_DEF = 16384;
	localparam int XFER_DEPTH      = 8;
	localparam int STIM_CH         = 2;
	localparam int NUM_CFG_DEF     = 4;

	// ------------------------------------------------------------
	// 16-bit command word layout: opcode, address, data
	// ------------------------------------------------------------
	localparam int         OP_POS     = 14;
	localparam int         ADDR_POS   = 8;
	localparam logic [1:0] OP_CONVERT = 2'h0;
	localparam logic [1:0] OP_WRITE   = 2'h2;
	localparam logic [1:0] OP_READ    = 2'h3;
	localparam logic [5:0] AUX_RD_ADDR = 6'h3C;

	// ------------------------------------------------------------
	// states and carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CONFIG = 3'h1,
		ST_ACQ    = 3'h3,
		ST_DRAIN  = 3'h2,
		ST_DONE   = 3'h6
	} aas_state_t;

	typedef enum logic [1:0] {
		XF_IDLE     = 2'h0,
		XF_WAIT     = 2'h1,
		XF_COMPLETE = 2'h3,
		XF_ERROR    = 2'h2
	} aas_xfer_t;

	// one streamed sample: conversion index and raw response word
	typedef struct packed {
		logic [5:0]  index;
		logic [31:0] data;
	} aas_resp_t;

endpackage

// *** aas_fifo.sv ***
// aas_fifo: synchronous fifo with a registered read stage.
// assumes: one clock, active-low reset already synchronised by the user.
`timescale 1ns/1ps
`default_nettype none
module aas_fifo #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	// nothing held anywhere
	output logic                  empty
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("aas_fifo depth must be a power of two, at least two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	logic             valid_reg;
	logic [WIDTH-1:0] data_reg;
	wire  [AW:0]      count = wr_reg - rd_reg;
	wire              push  = in_valid && in_ready;
	wire              load  = (count != '0) && (!valid_reg || out_ready);

	// full counts only the memory; the output stage is one extra slot
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = valid_reg;
	assign out_data  = data_reg;
	assign empty     = (count == '0) && !valid_reg;

	// storage has no reset so it can map to ram
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end

	// pointers and the registered read stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			valid_reg <= 1'b0;
			data_reg  <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (load) begin
				rd_reg    <= rd_reg + 1'b1;
				data_reg  <= mem[rd_reg[AW-1:0]];
				valid_reg <= 1'b1;
			end else if (out_ready) begin
				valid_reg <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** aas_sequencer.sv ***
// aas_sequencer: sample tick, command bursts over spi, result storage
// and serial streaming for a multichannel amplifier chip.
// assumes: control inputs come from logic on clk; link_clk is a free
// running clock owned by this block; spi_miso follows our own sclk.
`timescale 1ns/1ps
`default_nettype none
// Function
// - sample tick fires at 20 kHz, one sample period per tick
// - before acquiring, write computed register values over spi
// - recording variant: 35 words, 32 convert plus 3 aux, 16-bit
// - stimulating variant: 20 words, 16 convert then aux, 32-bit
// - one aux slot rewrites one register value per burst, each in turn
// - green led turns on in the same cycle the sample tick is enabled
// - each tick starts a burst unless one is still running, and drops idle monitor low briefly
// - tick monitor high only during tick handling, one per period
// - tick during an unfinished burst raises the overrun error
// - transfer state: wait at start, complete at end, error on error
// - words move to spi without the tick logic, across the burst
// - offline mode stores the selected conversion result locally
// - real-time mode streams selected channels every sample period
// - offline acquisition stops after 10000 samples, ticks disabled
// - real-time acquisition never stops
// - after offline stop, stored samples go out in small transfers
// - when all is finished, led off and stay idle for good
// - stim variant: trigger rising edge fires pulses on 2 channels
module aas_sequencer
	import aas_pkg::*;
#(
	parameter bit STIM_VARIANT = 1'b0,
	parameter int TICK_CYCLES  = TICK_CYCLES_DEF,
	parameter int SAMPLE_LIMIT = OFFLINE_SAMPLES,
	parameter int STORE_DEPTH  = STORE_DEPTH_DEF,
	parameter int NUM_CFG      = NUM_CFG_DEF
) (
	// clocks and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    link_clk,
	// control
	input  wire logic                    acq_start,
	input  wire logic                    offline_mode,
	input  wire logic                    auto_stim_en,
	input  wire logic [5:0]              store_chan,
	input  wire logic [31:0]             rt_chan_mask,
	input  wire logic [NUM_CFG-1:0][7:0] cfg_value,
	// spi pins and trigger pin
	output logic                         spi_cs_n,
	output logic                         spi_sclk,
	output logic                         spi_mosi,
	input  wire logic                    spi_miso,
	input  wire logic                    stim_trig_pin,
	// status
	output logic                         led_green,
	output logic                         tick_mon,
	output logic                         idle_mon,
	output logic                         overrun_error,
	output aas_xfer_t                    xfer_state,
	output logic [STIM_CH-1:0]           stim_fire,
	output logic                         acq_done,
	// serial stream
	output logic                         ser_valid,
	input  wire logic                    ser_ready,
	output aas_resp_t                    ser_data
);
	localparam int NUM_CONV = STIM_VARIANT ? STM_NUM_CONV : REC_NUM_CONV;
	localparam int NUM_AUX  = STIM_VARIANT ? STM_NUM_AUX : REC_NUM_AUX;
	localparam int WORD_W   = STIM_VARIANT ? STM_WORD_W : REC_WORD_W;
	localparam int BURST    = NUM_CONV + NUM_AUX;
	localparam int CFG_AW   = $clog2(NUM_CFG);
	localparam logic [5:0] BURST_LAST = 6'(BURST - 1);
	localparam logic [5:0] CFG_LAST   = 6'(NUM_CFG - 1);
	localparam logic [5:0] CONV_N     = 6'(NUM_CONV);
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	localparam logic [15:0] LIMIT     = 16'(SAMPLE_LIMIT);

	if (TICK_CYCLES < BURST * 2 || SAMPLE_LIMIT > 65535 ||
	    STORE_DEPTH < SAMPLE_LIMIT || NUM_CFG < 2 ||
	    (1 << CFG_AW) != NUM_CFG) begin : g_bad_param
		$error("aas_sequencer parameters out of range");
	end

	// ------------------------------------------------------------
	// reset release and pin synchronisers, system domain
	// ------------------------------------------------------------
	logic [1:0] rs_reg;
	wire        rst_n = rs_reg[1];
	logic       done_s1_reg, done_s2_reg, done_seen_reg;
	logic       trig_s1_reg, trig_s2_reg, trig_prev_reg;
	logic       done_tgl_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rs_reg <= 2'h0;
		end else begin
			rs_reg <= {rs_reg[0], 1'b1};
		end
	end

	// only the second stage of each pair is read by logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_s1_reg   <= 1'b0;
			done_s2_reg   <= 1'b0;
			trig_s1_reg   <= 1'b0;
			trig_s2_reg   <= 1'b0;
			trig_prev_reg <= 1'b0;
		end else begin
			done_s1_reg   <= done_tgl_reg;
			done_s2_reg   <= done_s1_reg;
			trig_s1_reg   <= stim_trig_pin;
			trig_s2_reg   <= trig_s1_reg;
			trig_prev_reg <= trig_s2_reg;
		end
	end

	// ------------------------------------------------------------
	// sequencer state and burst bookkeeping
	// ------------------------------------------------------------
	aas_state_t        state_reg;
	aas_xfer_t         xfer_reg;
	logic [31:0]       tick_cnt_reg;
	logic              busy_reg, req_tgl_reg;
	logic [5:0]        cur_idx_reg, burst_words_reg;
	logic [CFG_AW-1:0] aux_ptr_reg;
	logic [31:0]       cmd_word_reg, rx_word_reg;
	logic [15:0]       sample_cnt_reg;
	logic              led_reg, tick_mon_reg, idle_mon_reg, overrun_reg;
	logic              acq_done_reg;
	logic [STIM_CH-1:0] stim_reg;
	logic              store_in_ready, store_out_valid, store_empty;
	logic              xfer_in_ready, xfer_empty;
	aas_resp_t         store_out;

	wire in_cfg    = (state_reg == ST_CONFIG);
	wire in_acq    = (state_reg == ST_ACQ);
	wire in_drain  = (state_reg == ST_DRAIN);
	wire limit_hit = offline_mode && (sample_cnt_reg == LIMIT);
	wire tick_en   = in_acq && !limit_hit;
	wire tick      = tick_en && (tick_cnt_reg == TICK_LAST);
	wire done_evt  = done_s2_reg ^ done_seen_reg;
	wire is_last   = in_cfg ? (cur_idx_reg == CFG_LAST)
	                        : (cur_idx_reg == BURST_LAST);

	// result routing: one channel to the store, masked ones to the stream
	wire is_conv   = busy_reg && (cur_idx_reg < CONV_N);
	wire want_st   = is_conv && offline_mode &&
	                 (cur_idx_reg == store_chan);
	wire want_rt   = is_conv && !offline_mode &&
	                 rt_chan_mask[cur_idx_reg[4:0]];
	wire push_ok   = (!want_st || store_in_ready) &&
	                 (!want_rt || xfer_in_ready);
	wire consume   = done_evt && push_ok && (in_cfg || busy_reg);
	wire start_cfg = (state_reg == ST_IDLE) && acq_start;
	wire start_bst = tick && !busy_reg;
	wire overrun   = tick && busy_reg;
	wire step      = consume && !is_last;
	wire issue     = start_cfg || start_bst || step;
	wire bst_end   = consume && is_last && busy_reg;
	wire [5:0] issue_idx = (start_cfg || start_bst) ? 6'h00
	                                                : cur_idx_reg + 6'h01;

	// ------------------------------------------------------------
	// command word selection
	// ------------------------------------------------------------
	wire [5:0]  aux_slot  = issue_idx - CONV_N;
	wire [15:0] w_conv    = {OP_CONVERT, issue_idx, 8'h00};
	wire [15:0] w_cfg     = {OP_WRITE, 6'(issue_idx[CFG_AW-1:0]),
	                         cfg_value[issue_idx[CFG_AW-1:0]]};
	wire [15:0] w_refresh = {OP_WRITE, 6'(aux_ptr_reg),
	                         cfg_value[aux_ptr_reg]};
	wire [15:0] w_read    = {OP_READ, AUX_RD_ADDR + aux_slot, 8'h00};
	wire [15:0] w_sel     = in_cfg ? w_cfg
	                      : (issue_idx < CONV_N) ? w_conv
	                      : (aux_slot == 6'h00) ? w_refresh : w_read;
	// wide variant carries the 16-bit command in the upper half
	wire [31:0] w_full    = STIM_VARIANT ? {w_sel, 16'h0000}
	                                     : {16'h0000, w_sel};

	// word handshake toward the link; the tick only starts it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_tgl_reg   <= 1'b0;
			cmd_word_reg  <= '0;
			cur_idx_reg   <= '0;
			done_seen_reg <= 1'b0;
		end else begin
			if (consume) begin
				done_seen_reg <= done_s2_reg;
			end
			if (issue) begin
				cmd_word_reg <= w_full;
				cur_idx_reg  <= issue_idx;
				req_tgl_reg  <= ~req_tgl_reg;
			end
		end
	end

	// main sequence: configure, acquire, drain, finish
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= ST_IDLE;
			led_reg      <= 1'b0;
			acq_done_reg <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (start_cfg) begin
					state_reg <= ST_CONFIG;
				end
			end
			ST_CONFIG: begin
				if (consume && is_last) begin
					led_reg   <= 1'b1;
					state_reg <= ST_ACQ;
				end
			end
			ST_ACQ: begin
				// real-time mode never hits the limit, so stays here
				if (limit_hit && !busy_reg) begin
					state_reg <= ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (store_empty && xfer_empty) begin
					led_reg      <= 1'b0;
					acq_done_reg <= 1'b1;
					state_reg    <= ST_DONE;
				end
			end
			ST_DONE: begin
				state_reg <= ST_DONE;
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// tick timer, monitors, burst flags and overrun
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg    <= '0;
			busy_reg        <= 1'b0;
			xfer_reg        <= XF_IDLE;
			overrun_reg     <= 1'b0;
			tick_mon_reg    <= 1'b0;
			idle_mon_reg    <= 1'b1;
			aux_ptr_reg     <= '0;
			burst_words_reg <= '0;
		end else begin
			tick_cnt_reg <= (!tick_en || tick) ? '0 : tick_cnt_reg + 1'b1;
			tick_mon_reg <= tick;
			idle_mon_reg <= !tick;
			if (start_bst) begin
				busy_reg        <= 1'b1;
				burst_words_reg <= 6'h01;
			end else if (step && busy_reg) begin
				burst_words_reg <= burst_words_reg + 6'h01;
			end
			if (bst_end) begin
				busy_reg <= 1'b0;
			end
			if (issue && busy_reg && !in_cfg && aux_slot == 6'h00) begin
				aux_ptr_reg <= aux_ptr_reg + 1'b1;
			end
			// an error wins over a completion in the same cycle
			if (overrun || overrun_reg) begin
				overrun_reg <= 1'b1;
				xfer_reg    <= XF_ERROR;
			end else if (start_bst) begin
				xfer_reg <= XF_WAIT;
			end else if (bst_end) begin
				xfer_reg <= XF_COMPLETE;
			end
		end
	end

	// sample count and stimulation trigger
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_cnt_reg <= '0;
			stim_reg       <= '0;
		end else begin
			if (consume && want_st) begin
				sample_cnt_reg <= sample_cnt_reg + 16'h0001;
			end
			stim_reg <= (STIM_VARIANT && auto_stim_en && in_acq &&
			             trig_s2_reg && !trig_prev_reg)
			            ? {STIM_CH{1'b1}} : '0;
		end
	end

	// ------------------------------------------------------------
	// local store and the eight-word stream buffer
	// ------------------------------------------------------------
	aas_resp_t rx_tag;
	assign rx_tag = '{index: cur_idx_reg, data: rx_word_reg};
	wire        xfer_in_valid = (done_evt && want_rt) ||
	                            (in_drain && store_out_valid);
	aas_resp_t  xfer_in_data;
	assign xfer_in_data = in_drain ? store_out : rx_tag;

	aas_fifo #(.WIDTH($bits(aas_resp_t)), .DEPTH(STORE_DEPTH)) u_store (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (done_evt && want_st),
		.in_ready  (store_in_ready),
		.in_data   (rx_tag),
		.out_valid (store_out_valid),
		.out_ready (in_drain && xfer_in_ready),
		.out_data  (store_out),
		.empty     (store_empty)
	);

	// a stalled serial port holds results back and so stretches bursts
	aas_fifo #(.WIDTH($bits(aas_resp_t)), .DEPTH(XFER_DEPTH)) u_xfer (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (xfer_in_valid),
		.in_ready  (xfer_in_ready),
		.in_data   (xfer_in_data),
		.out_valid (ser_valid),
		.out_ready (ser_ready),
		.out_data  (ser_data),
		.empty     (xfer_empty)
	);

	assign led_green     = led_reg;
	assign tick_mon      = tick_mon_reg;
	assign idle_mon      = idle_mon_reg;
	assign overrun_error = overrun_reg;
	assign xfer_state    = xfer_reg;
	assign stim_fire     = stim_reg;
	assign acq_done      = acq_done_reg;

	// ------------------------------------------------------------
	// spi engine, link domain
	// ------------------------------------------------------------
	logic [1:0]  lrs_reg;
	wire         lrst_n = lrs_reg[1];
	logic        req_s1_reg, req_s2_reg, req_seen_reg;
	logic        active_reg, sclk_reg, cs_n_reg, mosi_reg;
	logic [31:0] tx_reg, rxs_reg;
	logic [5:0]  bit_reg;
	wire         lstart = (req_s2_reg ^ req_seen_reg) && !active_reg;
	// command sits msb first; narrow words are moved up to bit 31
	wire [31:0]  tx_load = STIM_VARIANT ? cmd_word_reg
	                                    : {cmd_word_reg[15:0], 16'h0000};

	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			lrs_reg <= 2'h0;
		end else begin
			lrs_reg <= {lrs_reg[0], 1'b1};
		end
	end

	// cmd_word_reg is stable from its toggle until our answer toggle
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			req_s1_reg   <= 1'b0;
			req_s2_reg   <= 1'b0;
			req_seen_reg <= 1'b0;
			active_reg   <= 1'b0;
			sclk_reg     <= 1'b0;
			cs_n_reg     <= 1'b1;
			mosi_reg     <= 1'b0;
			tx_reg       <= '0;
			rxs_reg      <= '0;
			bit_reg      <= '0;
			rx_word_reg  <= '0;
			done_tgl_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			if (lstart) begin
				req_seen_reg <= req_s2_reg;
				active_reg   <= 1'b1;
				cs_n_reg     <= 1'b0;
				tx_reg       <= tx_load;
				mosi_reg     <= tx_load[31];
				rxs_reg      <= '0;
				bit_reg      <= 6'(WORD_W - 1);
			end else if (active_reg && !sclk_reg) begin
				sclk_reg <= 1'b1;
				rxs_reg  <= {rxs_reg[30:0], spi_miso};
			end else if (active_reg) begin
				sclk_reg <= 1'b0;
				if (bit_reg == 6'h00) begin
					active_reg   <= 1'b0;
					cs_n_reg     <= 1'b1;
					rx_word_reg  <= rxs_reg;
					done_tgl_reg <= ~done_tgl_reg;
				end else begin
					bit_reg  <= bit_reg - 6'h01;
					tx_reg   <= {tx_reg[30:0], 1'b0};
					mosi_reg <= tx_reg[30];
				end
			end
		end
	end

	assign spi_cs_n = cs_n_reg;
	assign spi_sclk = sclk_reg;
	assign spi_mosi = mosi_reg;

	// ------------------------------------------------------------
	// checks, system domain
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_TICK_ALIGN: assert property (
		tick_mon_reg |-> tick_cnt_reg == 32'h0 && $past(tick_cnt_reg) == TICK_LAST
	) else $error("tick not at end of sample period");
	AST_LED_ON: assert property (
		$rose(state_reg == ST_ACQ) |-> led_reg && tick_cnt_reg == 32'h0
	) else $error("led not on when ticks enabled");
	AST_IDLE_LOW: assert property (
		tick |=> !idle_mon_reg ##1 idle_mon_reg
	) else $error("idle monitor not pulsed low on tick");
	AST_TICK_MON: assert property (
		tick |=> tick_mon_reg ##1 !tick_mon_reg
	) else $error("tick monitor not one cycle");
	AST_OVERRUN: assert property (
		tick && busy_reg |=> overrun_reg && xfer_reg == XF_ERROR
	) else $error("overrun not flagged");
	AST_XFER_WAIT: assert property (
		start_bst && !overrun_reg |=> busy_reg && xfer_reg == XF_WAIT
	) else $error("transfer state not waiting at burst start");
	AST_BURST_LEN: assert property (
		bst_end |-> burst_words_reg == 6'(BURST)
	) else $error("burst length wrong");
	AST_STOP: assert property (
		limit_hit |-> !tick ##1 !tick_mon_reg
	) else $error("tick after sample limit");
	AST_STIM: assert property (
		stim_reg != '0 |-> $past(state_reg) == ST_ACQ && $past(auto_stim_en)
	) else $error("stimulation outside acquisition");
	AST_LED_OFF: assert property (
		state_reg == ST_DONE |-> !led_reg && !tick && !busy_reg
	) else $error("led on or activity after finish");

	COV_BURST: cover property (start_bst ##[1:1000] bst_end);
	COV_OVERRUN: cover property (overrun);
	COV_DONE: cover property ($rose(state_reg == ST_DONE));
	COV_STIM: cover property (stim_reg != '0);
endmodule
`default_nettype wire

// *** aas_amp_model.sv ***
// aas_amp_model: spi slave stand-in for the amplifier chip.
// assumes: one command word per chip-select low period.
`timescale 1ns/1ps
`default_nettype none
module aas_amp_model (
	// spi pins
	input  wire logic spi_cs_n,
	input  wire logic spi_sclk,
	input  wire logic spi_mosi,
	output logic      spi_miso,
	// words seen so far
	output int        frames
);
	initial frames = 0;
	initial spi_miso = 1'b0;
	// ------------------------------------------------------------
	// one frame per word, counted at chip-select fall
	// ------------------------------------------------------------
	always @(negedge spi_cs_n) begin
		frames <= frames + 1;
	end
	// bits change on sclk fall; once released the line shows the
	// inverse, so a design sampling outside a frame gets no stale bit
	always @(negedge spi_sclk or edge spi_cs_n) begin
		spi_miso <= spi_cs_n ? ~spi_miso : 1'($urandom);
	end
endmodule
`default_nettype wire

// *** test_amplifier_sample_sequencer.sv ***
// test_amplifier_sample_sequencer: offline and real-time runs side by side.
// assumes: package, fifo, sequencer and amp model compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_amplifier_sample_sequencer;
	import aas_pkg::*;
	localparam int TK = 16000;	// long enough for a full 35-word burst
	localparam int LIM = 4;
	logic clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, go = 1'b0;
	logic trig = 1'b0, rdy = 1'b0;
	logic [5:0] chan = 6'h00;
	logic [31:0] mask = 32'h0;
	logic [3:0][7:0] cfg = 32'h0;
	wire [1:0] cs, sck, mo, mi, led, tmon, imon, ovr, sv, done;
	aas_xfer_t xs [2];
	aas_resp_t sd [2];
	wire [1:0] sf [2];
	int fr [2];
	int err_count = 0, check_count = 0;
	int cyc = 0, nt = 0, lt = 0, lf = 0, ns = 0;
	always #2.5 clk = ~clk;
	always #24 link_clk = ~link_clk;
	// ------------------------------------------------------------
	// unit 0 offline, unit 1 real-time with a too short period
	// ------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g
		aas_sequencer #(.STIM_VARIANT(i == 1),
			.TICK_CYCLES(i ? 2000 : TK), .SAMPLE_LIMIT(LIM),
			.STORE_DEPTH(8)) dut_u (.clk(clk), .resetn(resetn),
			.link_clk(link_clk), .acq_start(go), .offline_mode(i == 0),
			.auto_stim_en(trig), .store_chan(chan), .rt_chan_mask(mask),
			.cfg_value(cfg), .spi_cs_n(cs[i]), .spi_sclk(sck[i]),
			.spi_mosi(mo[i]), .spi_miso(mi[i]), .stim_trig_pin(trig),
			.led_green(led[i]), .tick_mon(tmon[i]), .idle_mon(imon[i]),
			.overrun_error(ovr[i]), .xfer_state(xs[i]), .stim_fire(sf[i]),
			.acq_done(done[i]), .ser_valid(sv[i]), .ser_ready(rdy),
			.ser_data(sd[i]));
		aas_amp_model amp_u (.spi_cs_n(cs[i]), .spi_sclk(sck[i]),
			.spi_mosi(mo[i]), .spi_miso(mi[i]), .frames(fr[i]));
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tmo(input int n, input int b);
		if (n >= b) begin
			err_count++;
			$display("[FAIL] t=%0t wait %0h of %0h", $time, n, b);
			end_sim();
		end
	endtask
	// random ready stalls the stream, trigger toggles at random
	always @(posedge clk) #1 begin
		rdy = 1'($urandom);
		trig = 1'($urandom);
	end
	// per-tick and per-stream-word checks, on the falling edge so that
	// registered outputs have settled and rdy is what the next edge takes
	always @(negedge clk) begin
		if (sf[0] !== 2'h0) chk(sf[0], 2'h0);
		if (sf[1] !== 2'h0) chk(sf[1], 2'h3);
		cyc <= cyc + 1;
		if (tmon[0] === 1'b1) begin
			chk(imon[0], 1'b0);
			chk(xs[0], XF_WAIT);
			if (nt > 0) chk(cyc - lt, TK);
			if (nt > 0) chk(fr[0] - lf, 35);
			nt <= nt + 1;
			lt <= cyc;
			lf <= fr[0];
		end
		if (sv[0] === 1'b1 && rdy === 1'b1) begin
			chk(sd[0].index, chan);
			ns <= ns + 1;
		end
		if (sv[1] === 1'b1 && rdy === 1'b1)
			chk(mask[sd[1].index], 1'b1);
	end
	initial begin : main
		int n;
		void'($urandom(32'h92B56F7B));
		chan = 6'($urandom_range(31));
		mask = $urandom;
		cfg = $urandom;
		repeat (20) @(posedge clk);
		chk({cs, imon, led, ovr}, 8'hF0);
		#1 resetn = 1'b1;
		repeat (3) @(posedge clk);
		#1 go = 1'b1;
		for (n = 0; n < 20000 && led[0] !== 1'b1; n++) @(posedge clk);
		tmo(n, 20000);
		#1 go = 1'b0;
		chk(fr[0], NUM_CFG_DEF);
		chk(nt, 0);
		for (n = 0; n < 30000 && ovr[1] !== 1'b1; n++) @(posedge clk);
		tmo(n, 30000);
		chk(xs[1], XF_ERROR);
		for (n = 0; n < 90000 && done[0] !== 1'b1; n++) @(posedge clk);
		tmo(n, 90000);
		chk(ns, LIM);
		chk(led[0], 1'b0);
		chk(ovr[0], 1'b0);
		chk(done[1], 1'b0);
		repeat (TK) @(posedge clk);
		chk(nt, LIM);
		end_sim();
	end
endmodule
`default_nettype wire
